/* tb/fieldbus_master.sv */
// fieldbus_master: behavioural master that issues object requests to the bank.
// assumes the bank answers each request with a one-cycle ack, never stalling.
`timescale 1ns/1ns
module fieldbus_master import power_meas_pkg::*; (
  input wire logic clk_sys,
  output obj_req_t obj_req,
  input wire obj_rsp_t obj_rsp
);
  initial obj_req = '0;

  // valid is a one-cycle pulse; holding it longer would issue a second request
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sb,
                      input logic [63:0] wd, output logic err, output logic [63:0] rd);
    @(negedge clk_sys);
    obj_req <= '{1'b1, wr, idx, sb, wd};
    @(negedge clk_sys);
    // released lines show the inverse so a stale value is never mistaken for live
    obj_req <= '{1'b0, ~wr, ~idx, ~sb, ~wd};
    err = 1'bx;
    rd = 'x;
    if (obj_rsp.ack !== 1'b1) begin
      @(negedge clk_sys);
    end
    if (obj_rsp.ack === 1'b1) begin
      err = obj_rsp.err;
      rd = obj_rsp.rdata;
    end
  endtask : xfer
endmodule : fieldbus_master

/* tb/power_meter_object_bank_tb_top.sv */
// power_meter_object_bank_tb_top: self-checking bench for the object bank.
// assumes a short second (TL cycles) and a master model driving the object bus.
`timescale 1ns/1ns
module power_meter_object_bank_tb_top import power_meas_pkg::*;;
  localparam int TL = 10;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  obj_req_t obj_req;
  obj_rsp_t obj_rsp;
  meas_t [NUM_CH-1:0] meas_data = '0;
  logic [NUM_CH-1:0] meas_load = '0;
  logic [31:0] meas_mode, meas_interval;
  logic interval_restart;
  logic [63:0] system_time;
  neutral_cfg_t neutral_cfg;
  logic [NUM_CH-1:0] update_toggle;
  logic [NUM_CH-1:0][VCAL_WORDS-1:0][31:0] vendor_cal;
  int fails = 0, cmp_count = 0, seed = 32'h8da5c5a6, c, n;
  logic e, tog;
  logic [63:0] r, w;
  logic [703:0] raw;
  meas_t m;
  logic [6:0] fl;
  logic [31:0] vlt [NUM_CH] = '{default: 32'h0};
  logic [31:0] codes [3] = '{RANGE_100MA, RANGE_1A, RANGE_5A};

  always #50 clk_sys = ~clk_sys;

  fieldbus_master bus (.clk_sys(clk_sys), .obj_req(obj_req), .obj_rsp(obj_rsp));
  power_meter_object_bank #(.CH(NUM_CH), .TICK_LEN(TL)) DUT (.clk_sys(clk_sys),
    .rst_n(rst_n), .obj_req(obj_req), .obj_rsp(obj_rsp), .meas_data(meas_data),
    .meas_load(meas_load), .meas_mode(meas_mode), .meas_interval(meas_interval),
    .interval_restart(interval_restart), .system_time(system_time),
    .neutral_cfg(neutral_cfg), .vendor_cal(vendor_cal), .update_toggle(update_toggle));

  function automatic logic [15:0] ix(input logic [15:0] b, input int ch);
    return b | 16'(ch << 4);
  endfunction : ix

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one object access, checking both the error flag and the returned data
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sb,
                     input logic [63:0] wd, input logic xe, input logic [63:0] xr);
    bus.xfer(wr, idx, sb, wd, e, r);
    chk("err", {63'h0, xe}, {63'h0, e});
    chk("rdata", xr, r);
  endtask : acc

  task automatic summarize;
    $display("counts: %0d comparisons, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(100 * 20000);
    fails++;
    summarize();
  end

  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    // reset values of settings and channel objects
    acc(0, IDX_TIME, SUB_MODE, 0, 0, MODE_RESET);
    acc(0, IDX_TIME, SUB_INTERVAL, 0, 0, INTERVAL_RESET);
    acc(0, IDX_NEUTRAL, SUB_CT_RATIO, 0, 0, REAL_ONE);
    acc(0, IDX_NEUTRAL, SUB_CT_DELAY, 0, 0, REAL_ZERO);
    acc(0, IDX_NEUTRAL, SUB_RANGE, 0, 0, RANGE_RESET);
    acc(0, IDX_USCALE, SUB_UCAL_EN, 0, 0, 0);
    acc(1, IDX_NEUTRAL, SUB_MAX, 1, 1, 0);
    for (c = 0; c < NUM_CH; c++) begin
      acc(0, ix(IDX_STATUS, c), 8'h02, 0, 0, 0);
      acc(0, ix(IDX_STATUS, c), SUB_TOGGLE, 0, 0, 0);
      acc(0, ix(IDX_BASIC, c), SUB_FIRST, 0, 0, REAL_ZERO);
      acc(0, ix(IDX_VENDOR, c), 8'h12, 0, 0, REAL_ONE);
    end
    $display("test reset values done");
    // every range code accepted, an illegal one refused and the old code kept
    foreach (codes[i]) begin
      acc(1, IDX_NEUTRAL, SUB_RANGE, codes[i], 0, 0);
      chk("range", codes[i], neutral_cfg.range);
    end
    acc(1, IDX_NEUTRAL, SUB_RANGE, 64'h3e7, 1, 0);
    chk("range kept", RANGE_5A, neutral_cfg.range);
    acc(1, IDX_NEUTRAL, SUB_CT_RATIO, 64'h40400000, 0, 0);
    chk("ratio", 32'h40400000, neutral_cfg.ratio);
    acc(1, IDX_NEUTRAL, SUB_CT_DELAY, 64'h3f000000, 0, 0);
    chk("delay", 32'h3f000000, neutral_cfg.delay_ms);
    acc(1, IDX_TIME, SUB_MODE, 64'h1, 0, 0);
    chk("mode", 1, meas_mode);
    acc(1, IDX_USCALE, SUB_UCAL_OFS, 64'h40000000, 0, 0);
    chk("ofs off", REAL_ZERO, neutral_cfg.ucal_ofs);
    acc(1, IDX_USCALE, SUB_UCAL_EN, 1, 0, 0);
    chk("ofs on", 32'h40000000, neutral_cfg.ucal_ofs);
    acc(1, IDX_USCALE, SUB_UCAL_GAIN, 64'h3fc00000, 0, 0);
    chk("gain on", 32'h3fc00000, neutral_cfg.ucal_gain);
    acc(1, IDX_USCALE, SUB_UCAL_EN, 0, 0, 0);
    chk("gain off", REAL_ONE, neutral_cfg.ucal_gain);
    $display("test neutral settings done");
    // random engine data sets on random channels
    repeat (6) begin
      c = $unsigned($random(seed)) % NUM_CH;
      for (n = 0; n < 22; n++) raw[n*32 +: 32] = $random(seed);
      m = meas_t'(raw[$bits(meas_t)-1:0]);
      tog = update_toggle[c];
      meas_data[c] = m;
      meas_load[c] = 1'b1;
      @(negedge clk_sys);
      meas_load[c] = 1'b0;
      vlt[c] = m.rms_volts;
      chk("toggle", {63'h0, ~tog}, {63'h0, update_toggle[c]});
      fl = {m.sign, m.ovr_volt, m.ovr_amp, m.low_volt, m.low_amp, m.mon_warn, m.mon_err};
      for (n = 1; n < 8; n++) begin
        acc(0, ix(IDX_STATUS, c), 8'(n), 0, 0, fl[7-n]);
      end
      acc(0, ix(IDX_BASIC, c), 8'h11, 0, 0, m.rms_volts);
      acc(0, ix(IDX_BASIC, c), 8'h12, 0, 0, m.rms_amps);
      acc(1, ix(IDX_BASIC, c), 8'h11, 64'h1, 1, 0);
      acc(0, ix(IDX_POWER, c), 8'h11, 0, 0, m.p_watt);
      acc(0, ix(IDX_POWER, c), 8'h12, 0, 0, m.s_va);
      acc(0, ix(IDX_POWER, c), 8'h13, 0, 0, m.q_var);
      acc(0, ix(IDX_POWER, c), 8'h14, 0, 0, m.pf);
      acc(0, ix(IDX_ENERGY, c), 8'h11, 0, 0, m.e_wh);
      acc(0, ix(IDX_ENERGY, c), 8'h13, 0, 0, m.e_varh);
      acc(0, ix(IDX_EFUND, c), 8'h12, 0, 0, m.ef_vah);
      acc(0, ix(IDX_BASIC, (c + 1) % 3), 8'h11, 0, 0, vlt[(c + 1) % 3]);
      w = {32'h0, 32'($random(seed))};
      acc(1, ix(IDX_VENDOR, c), 8'h1c, w, 0, 0);
      acc(0, ix(IDX_VENDOR, c), 8'h1c, 0, 0, w);
      chk("vendor", w, {32'h0, vendor_cal[c][VCAL_WORDS-1]});
    end
    acc(0, ix(IDX_BASIC, 3), 8'h11, 0, 1, 0);
    $display("test channel data done");
    // system time written, read and counting; interval restart spacing
    // align to a second tick so the next one lands at a known cycle
    w = system_time;
    for (n = 0; n < 100 && system_time === w; n++) @(negedge clk_sys);
    acc(1, IDX_TIME, SUB_SYSTIME, 64'h100000000, 0, 0);
    chk("time", 64'h100000000, system_time);
    acc(0, IDX_TIME, SUB_SYSTIME, 0, 0, 64'h100000000);
    repeat (TL) @(negedge clk_sys);
    chk("time tick", 64'h100000001, system_time);
    acc(1, IDX_TIME, SUB_INTERVAL, 2, 0, 0);
    chk("interval", 2, meas_interval);
    for (n = 0; n < 100 && interval_restart !== 1'b1; n++) @(negedge clk_sys);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (interval_restart !== 1'b1 && n < 100);
    chk("restart gap", 2 * TL, n);
    $display("test time and interval done");
    summarize();
  end
endmodule : power_meter_object_bank_tb_top

/* verilog/power_meas_pkg.sv */
// power_meas_pkg: object indices, subindices, reset values, timing constants
// and the packed structs shared by the object bank and its second ticker.
// assumes one 10 MHz system clock and a synchronous active-low reset.
package power_meas_pkg;

  localparam int NUM_CH = 3;
  localparam int VCAL_WORDS = 12;

  // object indices; the channel digit sits in index bits [7:4]
  localparam logic [15:0] CH_DIGIT_MASK = 16'hff0f;
  localparam logic [15:0] IDX_STATUS = 16'h6000;
  localparam logic [15:0] IDX_BASIC = 16'h6001;
  localparam logic [15:0] IDX_POWER = 16'h6002;
  localparam logic [15:0] IDX_PFUND = 16'h6003;
  localparam logic [15:0] IDX_ENERGY = 16'h6004;
  localparam logic [15:0] IDX_EFUND = 16'h6005;
  localparam logic [15:0] IDX_VENDOR = 16'h800f;
  localparam logic [15:0] IDX_TIME = 16'hf803;
  localparam logic [15:0] IDX_NEUTRAL = 16'hf804;
  localparam logic [15:0] IDX_USCALE = 16'hf805;

  // subindices
  localparam logic [7:0] SUB_MAX = 8'h00;
  localparam logic [7:0] SUB_TOGGLE = 8'h10;
  localparam logic [7:0] SUB_FIRST = 8'h11;
  localparam logic [7:0] SUB_MODE = 8'h11;
  localparam logic [7:0] SUB_INTERVAL = 8'h12;
  localparam logic [7:0] SUB_SYSTIME = 8'h13;
  localparam logic [7:0] SUB_CT_RATIO = 8'h12;
  localparam logic [7:0] SUB_CT_DELAY = 8'h13;
  localparam logic [7:0] SUB_RANGE = 8'h14;
  localparam logic [7:0] SUB_UCAL_EN = 8'h01;
  localparam logic [7:0] SUB_UCAL_OFS = 8'h13;
  localparam logic [7:0] SUB_UCAL_GAIN = 8'h14;
  localparam logic [7:0] SUB_UCAL_PHASE = 8'h15;

  // highest subindex of each object except PFUND (0x14 given, 0x13 served), read back at subindex 0
  localparam logic [7:0] MAX_STATUS = 8'h10;
  localparam logic [7:0] MAX_BASIC = 8'h12;
  localparam logic [7:0] MAX_POWER = 8'h14;
  localparam logic [7:0] MAX_PFUND = 8'h14;
  localparam logic [7:0] MAX_ENERGY = 8'h13;
  localparam logic [7:0] MAX_EFUND = 8'h13;
  localparam logic [7:0] MAX_VENDOR = 8'h1c;
  localparam logic [7:0] MAX_TIME = 8'h13;
  localparam logic [7:0] MAX_NEUTRAL = 8'h14;
  localparam logic [7:0] MAX_USCALE = 8'h15;

  // reset values (single-precision floats where the object is REAL32)
  localparam logic [31:0] REAL_ZERO = 32'h00000000;
  localparam logic [31:0] REAL_ONE = 32'h3f800000;
  localparam logic [31:0] MODE_RESET = 32'h00000000;
  localparam logic [31:0] INTERVAL_RESET = 32'h00000000;
  localparam logic [31:0] RANGE_100MA = 32'h00000064;
  localparam logic [31:0] RANGE_1A = 32'h000003e8;
  localparam logic [31:0] RANGE_5A = 32'h00001388;
  localparam logic [31:0] RANGE_RESET = RANGE_1A;
  // vendor words holding a gain (subindex 0x12, 0x15, 0x18, 0x1b)
  localparam logic [VCAL_WORDS-1:0] VCAL_GAIN_MASK = 12'h492;

  // one second expressed in system clock cycles
  localparam longint SECOND_NS = 1000000000;
  localparam longint CLK_PERIOD_NS = 100;
  localparam int TICK_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);

  // one channel's data set as delivered by the measurement engine
  typedef struct packed {
    logic sign;
    logic ovr_volt;
    logic ovr_amp;
    logic low_volt;
    logic low_amp;
    logic mon_warn;
    logic mon_err;
    logic [31:0] rms_volts;
    logic [31:0] rms_amps;
    logic [31:0] p_watt;
    logic [31:0] s_va;
    logic [31:0] q_var;
    logic [31:0] pf;
    logic [31:0] pf_watt;
    logic [31:0] pf_va;
    logic [31:0] pf_var;
    logic [63:0] e_wh;
    logic [63:0] e_vah;
    logic [63:0] e_varh;
    logic [63:0] ef_wh;
    logic [63:0] ef_vah;
    logic [63:0] ef_varh;
  } meas_t;

  // neutral-current settings handed to the measurement engine
  typedef struct packed {
    logic [31:0] range;
    logic [31:0] ratio;
    logic [31:0] delay_ms;
    logic [31:0] ucal_ofs;
    logic [31:0] ucal_gain;
    logic [31:0] ucal_phase;
  } neutral_cfg_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] index;
    logic [7:0] sub;
    logic [63:0] wdata;
  } obj_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [63:0] rdata;
  } obj_rsp_t;

  typedef struct packed {
    logic [31:0] cycle_cnt;
    logic [31:0] sec_cnt;
    logic tick;
    logic restart;
  } ticker_state_t;

endpackage : power_meas_pkg

/* verilog/power_meter_object_bank.sv */
// power_meter_object_bank: indexed object store of a three-phase meter.
// assumes an external measurement engine computes every quantity and limit
// result; this block only latches, stores and serves them to the master.
`timescale 1ns/1ns

// Behaviour
// - three channel copies, channel digit 0..2
// - sign flag 1 positive, 0 negative
// - over-range voltage flag follows input, resets zero
// - over-range current flag follows input
// - low-voltage accuracy flag below threshold
// - low-current accuracy flag below threshold
// - voltage monitor warning on warning breach
// - voltage monitor error, independent of warning
// - update toggle inverts on each refresh
// - interval restarts after set seconds, resets 0
// - system time readable, writes adopted
// - neutral range 100/1000/5000, default 1000
// - transformer ratio stored, default 1.0, applied
// - transformer delay stored in ms, default 0
// - RMS volts and amps, REAL32, reset zero
// - active/apparent/reactive power, factor as REAL32
// - 64-bit signed energy counters, read-only
// - separate fundamental energy counters
module power_meter_object_bank import power_meas_pkg::*; #(
  parameter int CH = NUM_CH,
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire obj_req_t obj_req,
  output obj_rsp_t obj_rsp,
  input wire meas_t [CH-1:0] meas_data,
  input wire logic [CH-1:0] meas_load,
  output logic [31:0] meas_mode,
  output logic [31:0] meas_interval,
  output logic interval_restart,
  output logic [63:0] system_time,
  output neutral_cfg_t neutral_cfg,
  output logic [CH-1:0][VCAL_WORDS-1:0][31:0] vendor_cal,
  output logic [CH-1:0] update_toggle
);

  typedef struct packed {
    meas_t [CH-1:0] chan;
    logic [CH-1:0] toggle;
    logic [CH-1:0][VCAL_WORDS-1:0][31:0] vcal;
    logic [31:0] mode;
    logic [31:0] interval;
    logic interval_wr;
    logic [63:0] systime;
    logic [31:0] range;
    logic [31:0] ratio;
    logic [31:0] delay_ms;
    logic ucal_en;
    logic [31:0] ucal_ofs;
    logic [31:0] ucal_gain;
    logic [31:0] ucal_phase;
    neutral_cfg_t cfg_out;
    obj_rsp_t rsp;
  } bank_state_t;

  bank_state_t state_reg;
  bank_state_t state_next;
  logic sec_tick;
  logic [15:0] base_idx;
  logic [3:0] ch_digit;
  logic ch_ok;
  logic [1:0] ch_sel;
  logic [7:0] vsub;

  initial begin
    if (CH != NUM_CH) $error("power_meter_object_bank: exactly three channels are served");
  end

  sec_ticker #(
    .TICK_LEN(TICK_LEN)
  ) u_ticker (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .interval(state_reg.interval),
    .interval_wr(state_reg.interval_wr),
    .sec_tick(sec_tick),
    .interval_restart(interval_restart)
  );

  // split the index into object base and channel digit
  assign ch_digit = obj_req.index[7:4];
  assign base_idx = obj_req.index & CH_DIGIT_MASK;
  assign ch_ok = (ch_digit < 4'(CH));
  assign ch_sel = ch_ok ? ch_digit[1:0] : 2'h0;
  assign vsub = obj_req.sub - SUB_FIRST;

  // reset image: zero everywhere except the documented non-zero defaults
  function automatic bank_state_t reset_image();
    bank_state_t s;
    s = '0;
    for (int c = 0; c < CH; c++) begin
      for (int w = 0; w < VCAL_WORDS; w++) begin
        s.vcal[c][w] = VCAL_GAIN_MASK[w] ? REAL_ONE : REAL_ZERO;
      end
    end
    s.mode = MODE_RESET;
    s.interval = INTERVAL_RESET;
    s.range = RANGE_RESET;
    s.ratio = REAL_ONE;
    s.delay_ms = REAL_ZERO;
    s.ucal_gain = REAL_ONE;
    s.cfg_out.range = RANGE_RESET;
    s.cfg_out.ratio = REAL_ONE;
    s.cfg_out.ucal_gain = REAL_ONE;
    return s;
  endfunction : reset_image

  // read side of the object map; err set for anything not mapped
  function automatic logic [64:0] read_obj(input bank_state_t s, input logic [15:0] bi,
                                           input logic [7:0] sub, input logic [1:0] c,
                                           input logic cok);
    logic [64:0] r;
    meas_t m;
    logic [6:0] fl;
    r = {1'b1, 64'h0};
    m = s.chan[c];
    fl = {m.sign, m.ovr_volt, m.ovr_amp, m.low_volt, m.low_amp, m.mon_warn, m.mon_err};
    if (bi[15:8] == 8'h60 || bi == IDX_VENDOR) begin
      if (!cok) begin
        return r;
      end
    end
    case (bi)
      IDX_STATUS: begin
        if (sub == SUB_MAX) r = {1'b0, 56'h0, MAX_STATUS};
        else if (sub >= 8'h01 && sub <= 8'h07) begin
          r = {1'b0, 63'h0, fl[3'(8'h07 - sub)]};
        end else if (sub == SUB_TOGGLE) r = {1'b0, 63'h0, s.toggle[c]};
      end
      IDX_BASIC: begin
        if (sub == SUB_MAX) r = {1'b0, 56'h0, MAX_BASIC};
        else if (sub == 8'h11) r = {1'b0, 32'h0, m.rms_volts};
        else if (sub == 8'h12) r = {1'b0, 32'h0, m.rms_amps};
      end
      IDX_POWER: begin
        if (sub == SUB_MAX) r = {1'b0, 56'h0, MAX_POWER};
        else if (sub == 8'h11) r = {1'b0, 32'h0, m.p_watt};
        else if (sub == 8'h12) r = {1'b0, 32'h0, m.s_va};
        else if (sub == 8'h13) r = {1'b0, 32'h0, m.q_var};
        else if (sub == 8'h14) r = {1'b0, 32'h0, m.pf};
      end
      IDX_PFUND: begin
        if (sub == SUB_MAX) r = {1'b0, 56'h0, MAX_PFUND};
        else if (sub == 8'h11) r = {1'b0, 32'h0, m.pf_watt};
        else if (sub == 8'h12) r = {1'b0, 32'h0, m.pf_va};
        else if (sub == 8'h13) r = {1'b0, 32'h0, m.pf_var};
      end
      IDX_ENERGY: begin
        if (sub == SUB_MAX) r = {1'b0, 56'h0, MAX_ENERGY};
        else if (sub == 8'h11) r = {1'b0, m.e_wh};
        else if (sub == 8'h12) r = {1'b0, m.e_vah};
        else if (sub == 8'h13) r = {1'b0, m.e_varh};
      end
      IDX_EFUND: begin
        if (sub == SUB_MAX) r = {1'b0, 56'h0, MAX_EFUND};
        else if (sub == 8'h11) r = {1'b0, m.ef_wh};
        else if (sub == 8'h12) r = {1'b0, m.ef_vah};
        else if (sub == 8'h13) r = {1'b0, m.ef_varh};
      end
      IDX_VENDOR: begin
        if (sub == SUB_MAX) r = {1'b0, 56'h0, MAX_VENDOR};
        else if (sub >= SUB_FIRST && sub <= MAX_VENDOR) begin
          r = {1'b0, 32'h0, s.vcal[c][vsub[3:0]]};
        end
      end
      IDX_TIME: begin
        if (sub == SUB_MAX) r = {1'b0, 56'h0, MAX_TIME};
        else if (sub == SUB_MODE) r = {1'b0, 32'h0, s.mode};
        else if (sub == SUB_INTERVAL) r = {1'b0, 32'h0, s.interval};
        else if (sub == SUB_SYSTIME) r = {1'b0, s.systime};
      end
      IDX_NEUTRAL: begin
        if (sub == SUB_MAX) r = {1'b0, 56'h0, MAX_NEUTRAL};
        else if (sub == SUB_CT_RATIO) r = {1'b0, 32'h0, s.ratio};
        else if (sub == SUB_CT_DELAY) r = {1'b0, 32'h0, s.delay_ms};
        else if (sub == SUB_RANGE) r = {1'b0, 32'h0, s.range};
      end
      IDX_USCALE: begin
        if (sub == SUB_MAX) r = {1'b0, 56'h0, MAX_USCALE};
        else if (sub == SUB_UCAL_EN) r = {1'b0, 63'h0, s.ucal_en};
        else if (sub == SUB_UCAL_OFS) r = {1'b0, 32'h0, s.ucal_ofs};
        else if (sub == SUB_UCAL_GAIN) r = {1'b0, 32'h0, s.ucal_gain};
        else if (sub == SUB_UCAL_PHASE) r = {1'b0, 32'h0, s.ucal_phase};
      end
      default: begin
        r = {1'b1, 64'h0};
      end
    endcase
    return r;
  endfunction : read_obj

  // next state: engine latch, time keeping, object access, engine settings
  always_comb begin
    logic [64:0] rd;
    logic wr_ok;
    rd = '0;
    wr_ok = 1'b0;
    state_next = state_reg;
    state_next.rsp = '0;
    state_next.interval_wr = 1'b0;
    // engine data set latched whole; toggle marks a fresh set
    for (int c = 0; c < CH; c++) begin
      if (meas_load[c]) begin
        state_next.chan[c] = meas_data[c];
        state_next.toggle[c] = !state_reg.toggle[c];
      end
    end
    // a master write in the same cycle as the tick wins: time is adopted as written
    if (sec_tick) begin
      state_next.systime = state_reg.systime + 64'h1;
    end
    if (obj_req.valid) begin
      rd = read_obj(state_reg, base_idx, obj_req.sub, ch_sel, ch_ok);
      state_next.rsp.ack = 1'b1;
      if (!obj_req.write) begin
        state_next.rsp.err = rd[64];
        state_next.rsp.rdata = rd[63:0];
      end else begin
        if (base_idx == IDX_VENDOR && ch_ok && obj_req.sub >= SUB_FIRST
            && obj_req.sub <= MAX_VENDOR) begin
          state_next.vcal[ch_sel][vsub[3:0]] = obj_req.wdata[31:0];
          wr_ok = 1'b1;
        end else if (base_idx == IDX_TIME) begin
          wr_ok = 1'b1;
          case (obj_req.sub)
            SUB_MODE: state_next.mode = obj_req.wdata[31:0];
            SUB_INTERVAL: begin
              state_next.interval = obj_req.wdata[31:0];
              state_next.interval_wr = 1'b1;
            end
            SUB_SYSTIME: state_next.systime = obj_req.wdata;
            default: wr_ok = 1'b0;
          endcase
        end else if (base_idx == IDX_NEUTRAL) begin
          wr_ok = 1'b1;
          case (obj_req.sub)
            SUB_CT_RATIO: state_next.ratio = obj_req.wdata[31:0];
            SUB_CT_DELAY: state_next.delay_ms = obj_req.wdata[31:0];
            SUB_RANGE: begin
              // only the three range codes are taken; others leave the range alone
              if (obj_req.wdata[31:0] == RANGE_100MA || obj_req.wdata[31:0] == RANGE_1A
                  || obj_req.wdata[31:0] == RANGE_5A) begin
                state_next.range = obj_req.wdata[31:0];
              end else begin
                wr_ok = 1'b0;
              end
            end
            default: wr_ok = 1'b0;
          endcase
        end else if (base_idx == IDX_USCALE) begin
          wr_ok = 1'b1;
          case (obj_req.sub)
            SUB_UCAL_EN: state_next.ucal_en = obj_req.wdata[0];
            SUB_UCAL_OFS: state_next.ucal_ofs = obj_req.wdata[31:0];
            SUB_UCAL_GAIN: state_next.ucal_gain = obj_req.wdata[31:0];
            SUB_UCAL_PHASE: state_next.ucal_phase = obj_req.wdata[31:0];
            default: wr_ok = 1'b0;
          endcase
        end
        // read-only, unmapped or refused writes all answer with err
        state_next.rsp.err = !wr_ok;
      end
    end
    // engine sees the neutral settings; user cal is neutral while disabled
    state_next.cfg_out.range = state_next.range;
    state_next.cfg_out.ratio = state_next.ratio;
    state_next.cfg_out.delay_ms = state_next.delay_ms;
    state_next.cfg_out.ucal_ofs = state_next.ucal_en ? state_next.ucal_ofs : REAL_ZERO;
    state_next.cfg_out.ucal_gain = state_next.ucal_en ? state_next.ucal_gain : REAL_ONE;
    state_next.cfg_out.ucal_phase = state_next.ucal_en ? state_next.ucal_phase : REAL_ZERO;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= reset_image();
    end else begin
      state_reg <= state_next;
    end
  end

  assign obj_rsp = state_reg.rsp;
  assign meas_mode = state_reg.mode;
  assign meas_interval = state_reg.interval;
  assign system_time = state_reg.systime;
  assign neutral_cfg = state_reg.cfg_out;
  assign vendor_cal = state_reg.vcal;
  assign update_toggle = state_reg.toggle;

  sequence req_taken;
    obj_req.valid;
  endsequence

  sequence ack_next;
    ##1 obj_rsp.ack;
  endsequence

  a_req_answered: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req_taken |-> ack_next)
    else $error("object request not answered in one cycle");

  a_bad_channel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    obj_req.valid && obj_req.index[15:8] == 8'h60 && obj_req.index[7:4] > 4'h2
    |=> obj_rsp.err)
    else $error("channel digit above 2 was accepted");

  a_toggle_flips: assert property (@(posedge clk_sys) disable iff (!rst_n)
    meas_load[0] |=> update_toggle[0] != $past(update_toggle[0]))
    else $error("update toggle did not invert on refresh");

  a_toggle_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !meas_load[1] |=> $stable(update_toggle[1]))
    else $error("update toggle moved without a refresh");

  a_flags_latched: assert property (@(posedge clk_sys) disable iff (!rst_n)
    meas_load[2] |=> state_reg.chan[2].sign == $past(meas_data[2].sign)
      && state_reg.chan[2].ovr_volt == $past(meas_data[2].ovr_volt)
      && state_reg.chan[2].mon_warn == $past(meas_data[2].mon_warn)
      && state_reg.chan[2].mon_err == $past(meas_data[2].mon_err))
    else $error("status flags not taken from the engine set");

  a_range_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    obj_req.valid && obj_req.write && obj_req.index == IDX_NEUTRAL
      && obj_req.sub == SUB_RANGE && obj_req.wdata[31:0] != RANGE_100MA
      && obj_req.wdata[31:0] != RANGE_1A && obj_req.wdata[31:0] != RANGE_5A
    |=> obj_rsp.err && $stable(neutral_cfg.range))
    else $error("illegal range code was stored");

  a_ucal_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !state_reg.ucal_en |-> neutral_cfg.ucal_gain == REAL_ONE
      && neutral_cfg.ucal_ofs == REAL_ZERO && neutral_cfg.ucal_phase == REAL_ZERO)
    else $error("user calibration applied while disabled");

  a_time_adopted: assert property (@(posedge clk_sys) disable iff (!rst_n)
    obj_req.valid && obj_req.write && obj_req.index == IDX_TIME
      && obj_req.sub == SUB_SYSTIME
    |=> system_time == $past(obj_req.wdata))
    else $error("written system time not adopted");

  a_energy_ro: assert property (@(posedge clk_sys) disable iff (!rst_n)
    obj_req.valid && obj_req.write && (obj_req.index & CH_DIGIT_MASK) == IDX_ENERGY
    |=> obj_rsp.err)
    else $error("write to energy counter accepted");

endmodule : power_meter_object_bank

/* verilog/sec_ticker.sv */
// sec_ticker: one-second tick and the automatic interval restart pulse.
// assumes interval_wr pulses for one cycle when software rewrites the interval.
`timescale 1ns/1ns
module sec_ticker import power_meas_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [31:0] interval,
  input wire logic interval_wr,
  output logic sec_tick,
  output logic interval_restart
);

  ticker_state_t state_reg;
  ticker_state_t state_next;

  initial begin
    if (TICK_LEN < 2) $error("sec_ticker: TICK_LEN must be at least 2");
  end

  // prescaler, then seconds within the current interval
  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    state_next.restart = 1'b0;
    if (state_reg.cycle_cnt == 32'(TICK_LEN - 1)) begin
      state_next.cycle_cnt = 32'h00000000;
      state_next.tick = 1'b1;
    end else begin
      state_next.cycle_cnt = state_reg.cycle_cnt + 32'h00000001;
    end
    // interval zero means no automatic restart at all
    if (interval_wr) begin
      state_next.sec_cnt = 32'h00000000; // a new interval counts from scratch
    end else if (state_next.tick && interval != 32'h00000000) begin
      if (state_reg.sec_cnt + 32'h00000001 >= interval) begin
        state_next.sec_cnt = 32'h00000000;
        state_next.restart = 1'b1;
      end else begin
        state_next.sec_cnt = state_reg.sec_cnt + 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sec_tick = state_reg.tick;
  assign interval_restart = state_reg.restart;

  a_restart_needs_tick: assert property (@(posedge clk_sys) disable iff (!rst_n)
    interval_restart |-> sec_tick && interval != 32'h00000000)
    else $error("interval restart without a second tick");

  a_tick_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sec_tick |=> !sec_tick)
    else $error("second tick lasted two cycles");

endmodule : sec_ticker
